// ==== rtl/dcsc_pkg.sv ====
package dcsc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_SOFT_RST  = 8'h00;
  localparam logic [7:0] ADDR_SYNC_CTL  = 8'h02;
  localparam logic [7:0] ADDR_STATUS    = 8'h0d;
  localparam logic [7:0] ADDR_CAL_CLK   = 8'h0e;
  localparam logic [7:0] ADDR_CAL_CTL   = 8'h0f;
  localparam logic [7:0] ADDR_TRIM_ADR  = 8'h10;
  localparam logic [7:0] ADDR_TRIM_VAL  = 8'h11;
  localparam logic [7:0] ADDR_QUADRANT  = 8'h15;
  localparam logic [7:0] ADDR_RESYNC    = 8'h16;
  // Field positions
  localparam int SOFT_RST_BIT  = 7;
  localparam int MAN_MODE_BIT  = 2;
  localparam int MAN_UPD_BIT   = 1;
  localparam int ALARM_BIT     = 0;
  localparam int STATE_LSB     = 4;
  localparam int SC_DONE_BIT   = 7;
  localparam int SC_START_BIT  = 6;
  localparam int CP_DONE_BIT   = 5;
  localparam int CP_START_BIT  = 4;
  localparam int WT_WR_BIT     = 3;
  localparam int WT_RD_BIT     = 2;
  localparam int FT_RD_BIT     = 1;
  localparam int FORCE_BIT     = 0;
  localparam int BYPASS_BIT    = 6;
  localparam int EXT_BIT       = 5;
  localparam int QSEL_LSB      = 3;
  // Reset and default values
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [2:0] DIV_RST      = 3'h0;
  localparam logic [1:0] QUAD_RST     = 2'h0;
  localparam logic [5:0] TRIM_DEFAULT = 6'h3f;
  // Timing
  localparam logic [11:0] DIV_MAX_M1  = 12'hfff;
  localparam int DIV_MAX_RATIO        = 4096;
  localparam int CLK_KHZ              = 100000;
  localparam int SELF_CALIBRATION_START_TIME_MS      = 100;
  localparam int COPY_TIME_MS         = 15;
  localparam int SELF_CALIBRATION_START_CYCLES_DFLT  = SELF_CALIBRATION_START_TIME_MS * CLK_KHZ;
  localparam int COPY_CYCLES_DFLT     = COPY_TIME_MS * CLK_KHZ;
  // Calibration state codes, in reporting order
  typedef enum logic [1:0] {CS_FORCE_DEFAULT_TRIM, CS_SELF, CS_FACT, CS_USER} dcsc_cal_t;
  typedef enum logic [1:0] {E_IDLE, E_SELF, E_COPY} dcsc_eng_t;
endpackage

// ==== rtl/dcsc_top.sv ====
`timescale 1ns/1ps
module dcsc_top
  import dcsc_pkg::*;
#(
  parameter int SELF_CALIBRATION_START_CYCLES = SELF_CALIBRATION_START_CYCLES_DFLT,
  parameter int COPY_CYCLES    = COPY_CYCLES_DFLT
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] data_in,
  input  wire logic [1:0]  phase_quad,
  input  wire logic        cal_cmp,
  output logic      [15:0] dac_data,
  output logic      [7:0]  fac_addr,
  input  wire logic [5:0]  fac_data
);
  // Tick counts; a shortened simulation value never drops below one tick
  localparam int SC_TICKS = (SELF_CALIBRATION_START_CYCLES / DIV_MAX_RATIO > 0) ?
                            SELF_CALIBRATION_START_CYCLES / DIV_MAX_RATIO : 1;
  localparam int CP_TICKS = (COPY_CYCLES / DIV_MAX_RATIO > 0) ?
                            COPY_CYCLES / DIV_MAX_RATIO : 1;
  localparam logic [31:0] SC_LAST = 32'(SC_TICKS - 1);
  localparam logic [31:0] CP_LAST = 32'(CP_TICKS - 1);

  logic        rst_s_r, rst_q_n;
  logic [18:0] pin_s1_r, pin_s2_r;
  logic [15:0] din_s;
  logic [1:0]  pq_s;
  logic        cmp_s;
  logic        soft_p_r, man_mode_r, alarm_r, bypass_r, ext_r;
  logic [1:0]  qsel_r, quad_r, tgt;
  logic        upd_now, man_upd;
  logic [2:0]  div_r;
  logic [11:0] div_cnt_r, ratio_m1;
  logic [31:0] tick_cnt_r;
  logic        tick, busy, sc_done_ev, cp_done_ev;
  dcsc_eng_t   eng_r;
  dcsc_cal_t   cal_state_r;
  logic        sc_start_r, cp_start_r, sc_done_r, cp_done_r;
  logic        en_wr_r, en_rw_r, en_rf_r, force_r;
  logic        ctl_wr, low_ok, sc_acc, cp_acc, op_ok, wr_op, rw_op, rf_op;
  logic        rf_pend_r, cp_wr_r;
  logic [7:0]  cp_idx_r, trim_adr_r;
  logic [5:0]  trim_val_r;
  logic [5:0]  wtrim_r [256];
  logic [15:0] dly_r [3];

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s_r <= 1'b0;
      rst_q_n <= 1'b0;
    end else begin
      rst_s_r <= 1'b1;
      rst_q_n <= rst_s_r;
    end
  end

  // Pin synchronisers; quadrant bits move slowly, so per-bit sync is safe
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {cal_cmp, phase_quad, data_in};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign din_s = pin_s2_r[15:0];
  assign pq_s  = pin_s2_r[17:16];
  assign cmp_s = pin_s2_r[18];

  // Decode of register writes
  assign ctl_wr  = reg_wr_en && (reg_addr == ADDR_CAL_CTL);
  assign low_ok  = (reg_wdata[3:0] == 4'h0);
  assign busy    = (eng_r != E_IDLE);
  assign sc_acc  = ctl_wr && reg_wdata[SC_START_BIT] && low_ok && !busy;
  assign cp_acc  = ctl_wr && reg_wdata[CP_START_BIT] && !reg_wdata[SC_START_BIT]
                   && low_ok && !busy;
  assign op_ok   = ctl_wr && !busy && !soft_p_r;
  assign wr_op   = op_ok && reg_wdata[WT_WR_BIT];
  assign rw_op   = op_ok && reg_wdata[WT_RD_BIT];
  assign rf_op   = op_ok && reg_wdata[FT_RD_BIT];
  assign man_upd = reg_wr_en && (reg_addr == ADDR_SYNC_CTL) && reg_wdata[MAN_UPD_BIT];

  // Soft reset is a one-cycle pulse, so the bit always reads back 0
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      soft_p_r <= 1'b0;
    end else begin
      soft_p_r <= reg_wr_en && (reg_addr == ADDR_SOFT_RST) && reg_wdata[SOFT_RST_BIT];
    end
  end

  // Plain configuration registers
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      man_mode_r <= 1'b0;
      div_r      <= DIV_RST;
      trim_adr_r <= REG_RST;
      bypass_r   <= 1'b0;
      ext_r      <= 1'b0;
      qsel_r     <= QUAD_RST;
      en_wr_r    <= 1'b0;
      en_rw_r    <= 1'b0;
      en_rf_r    <= 1'b0;
      force_r    <= 1'b0;
    end else if (reg_wr_en) begin
      case (reg_addr)
        ADDR_SYNC_CTL: man_mode_r <= reg_wdata[MAN_MODE_BIT];
        ADDR_CAL_CLK:  div_r      <= reg_wdata[2:0];
        ADDR_TRIM_ADR: trim_adr_r <= reg_wdata;
        ADDR_RESYNC: begin
          bypass_r <= reg_wdata[BYPASS_BIT];
          ext_r    <= reg_wdata[EXT_BIT];
          qsel_r   <= reg_wdata[QSEL_LSB +: 2];
        end
        ADDR_CAL_CTL: begin
          en_wr_r <= reg_wdata[WT_WR_BIT];
          en_rw_r <= reg_wdata[WT_RD_BIT];
          en_rf_r <= reg_wdata[FT_RD_BIT];
          force_r <= reg_wdata[FORCE_BIT];
        end
        default: ;
      endcase
    end
  end

  // Synchroniser quadrant choice and alarm
  assign tgt     = ext_r ? qsel_r : pq_s;
  assign upd_now = ext_r || !man_mode_r || man_upd;
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      quad_r  <= QUAD_RST;
      alarm_r <= 1'b0;
    end else begin
      if (upd_now) begin
        quad_r <= tgt;
      end
      alarm_r <= (tgt != quad_r) && !upd_now;
    end
  end

  // Data path; quadrant picks 0..3 cycles of extra delay
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      dly_r[0] <= '0;
      dly_r[1] <= '0;
      dly_r[2] <= '0;
      dac_data <= '0;
    end else begin
      dly_r[0] <= din_s;
      dly_r[1] <= dly_r[0];
      dly_r[2] <= dly_r[1];
      if (bypass_r || quad_r == 2'h0) begin
        dac_data <= din_s;
      end else begin
        dac_data <= dly_r[quad_r - 2'h1];
      end
    end
  end

  // Calibration clock divider, shared by self-cal and copy
  assign ratio_m1   = DIV_MAX_M1 >> div_r;
  assign tick       = busy && (div_cnt_r >= ratio_m1);
  assign sc_done_ev = (eng_r == E_SELF) && tick && (tick_cnt_r == SC_LAST);
  assign cp_done_ev = (eng_r == E_COPY) && tick && (tick_cnt_r == CP_LAST);
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      div_cnt_r  <= '0;
      tick_cnt_r <= '0;
    end else if (!busy || tick) begin
      div_cnt_r  <= '0;
      tick_cnt_r <= busy ? tick_cnt_r + 32'h1 : 32'h0;
    end else begin
      div_cnt_r  <= div_cnt_r + 12'h1;
    end
  end

  // Engine; soft reset aborts a running cycle
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      eng_r <= E_IDLE;
    end else if (soft_p_r) begin
      eng_r <= E_IDLE;
    end else begin
      case (eng_r)
        E_IDLE: begin
          if (sc_acc) begin
            eng_r <= E_SELF;
          end else if (cp_acc) begin
            eng_r <= E_COPY;
          end
        end
        E_SELF: if (sc_done_ev) eng_r <= E_IDLE;
        E_COPY: if (cp_done_ev) eng_r <= E_IDLE;
        default: eng_r <= E_IDLE;
      endcase
    end
  end

  // Start and done flags; a done event beats a same-cycle clear
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      sc_start_r <= 1'b0;
      cp_start_r <= 1'b0;
      sc_done_r  <= 1'b0;
      cp_done_r  <= 1'b0;
    end else begin
      if (sc_acc) sc_start_r <= 1'b1;
      else if (sc_done_ev || soft_p_r) sc_start_r <= 1'b0;
      if (cp_acc) cp_start_r <= 1'b1;
      else if (cp_done_ev || soft_p_r) cp_start_r <= 1'b0;
      if (sc_done_ev) sc_done_r <= 1'b1;
      else if (sc_acc || soft_p_r) sc_done_r <= 1'b0;
      if (cp_done_ev) cp_done_r <= 1'b1;
      else if (cp_acc || soft_p_r) cp_done_r <= 1'b0;
    end
  end

  // Calibration state report
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      cal_state_r <= CS_FORCE_DEFAULT_TRIM;
    end else if (soft_p_r || force_r) begin
      cal_state_r <= CS_FORCE_DEFAULT_TRIM;
    end else if (sc_done_ev) begin
      cal_state_r <= CS_SELF;
    end else if (cp_done_ev) begin
      cal_state_r <= CS_FACT;
    end else if (wr_op) begin
      cal_state_r <= CS_USER;
    end
  end

  // Factory memory address; read data is taken one cycle later
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      fac_addr  <= REG_RST;
      rf_pend_r <= 1'b0;
      cp_wr_r   <= 1'b0;
      cp_idx_r  <= REG_RST;
    end else begin
      rf_pend_r <= rf_op;
      cp_wr_r   <= (eng_r == E_COPY) && tick;
      if ((eng_r == E_COPY) && tick) begin
        fac_addr <= tick_cnt_r[7:0];
        cp_idx_r <= tick_cnt_r[7:0];
      end else if (rf_op) begin
        fac_addr <= trim_adr_r;
      end
    end
  end

  // Trim value register, loaded by bus or by a read operation
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      trim_val_r <= TRIM_DEFAULT & 6'h00;
    end else if (rf_pend_r) begin
      trim_val_r <= fac_data;
    end else if (rw_op) begin
      trim_val_r <= wtrim_r[trim_adr_r];
    end else if (reg_wr_en && reg_addr == ADDR_TRIM_VAL) begin
      trim_val_r <= reg_wdata[5:0];
    end
  end

  // Working trim memory; contents survive a soft reset
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      for (int i = 0; i < 256; i++) wtrim_r[i] <= TRIM_DEFAULT;
    end else if (force_r) begin
      for (int i = 0; i < 256; i++) wtrim_r[i] <= TRIM_DEFAULT;
    end else begin
      // Self-cal nudges one location per tick toward the comparator
      if ((eng_r == E_SELF) && tick) begin
        if (cmp_s && wtrim_r[tick_cnt_r[7:0]] != 6'h00) begin
          wtrim_r[tick_cnt_r[7:0]] <= wtrim_r[tick_cnt_r[7:0]] - 6'h1;
        end else if (!cmp_s && wtrim_r[tick_cnt_r[7:0]] != TRIM_DEFAULT) begin
          wtrim_r[tick_cnt_r[7:0]] <= wtrim_r[tick_cnt_r[7:0]] + 6'h1;
        end
      end
      if (cp_wr_r) wtrim_r[cp_idx_r] <= fac_data;
      if (wr_op) wtrim_r[trim_adr_r] <= trim_val_r;
    end
  end

  // Registered read data; unmapped offsets read 0
  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      reg_rdata <= REG_RST;
    end else if (reg_rd_en) begin
      case (reg_addr)
        ADDR_SYNC_CTL: reg_rdata <= {5'h0, man_mode_r, 2'h0};
        ADDR_STATUS:   reg_rdata <= {7'h0, alarm_r};
        ADDR_CAL_CLK:  reg_rdata <= {2'h0, cal_state_r, 1'b0, div_r};
        ADDR_CAL_CTL:  reg_rdata <= {sc_done_r, sc_start_r, cp_done_r, cp_start_r,
                                     en_wr_r, en_rw_r, en_rf_r, force_r};
        ADDR_TRIM_ADR: reg_rdata <= trim_adr_r;
        ADDR_TRIM_VAL: reg_rdata <= {2'h0, trim_val_r};
        ADDR_QUADRANT: reg_rdata <= {6'h0, quad_r};
        ADDR_RESYNC:   reg_rdata <= {1'b0, bypass_r, ext_r, qsel_r, 3'h0};
        default:       reg_rdata <= REG_RST;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_q_n);

  a_alarm_manual: assert property (man_mode_r && !ext_r && !man_upd && tgt != quad_r
    ##1 !man_upd && !ext_r && man_mode_r |-> alarm_r) else $error("alarm missing");
  a_alarm_auto: assert property (!man_mode_r && !ext_r |=> !alarm_r)
    else $error("alarm in auto mode");
  a_state_self: assert property (sc_done_ev && !force_r && !soft_p_r |=> cal_state_r == CS_SELF)
    else $error("state not self");
  a_state_copy: assert property (cp_done_ev && !force_r && !soft_p_r |=> cal_state_r == CS_FACT)
    else $error("state not factory");
  a_div_ratio: assert property (busy && tick && div_r == 3'h7 |=> !tick [*8] ##24
    (tick || !busy || div_r != 3'h7)) else $error("divide by 32 wrong");
  a_sc_done_clr: assert property ($rose(sc_done_r) |-> !sc_start_r && $past(sc_start_r))
    else $error("start not cleared");
  a_cp_done_flag: assert property (cp_done_ev |=> cp_done_r && !cp_start_r)
    else $error("copy done missing");
  a_start_self: assert property (sc_acc && !soft_p_r |=> eng_r == E_SELF && sc_start_r)
    else $error("self-cal not started");
  a_user_write: assert property (wr_op && !force_r |=> wtrim_r[$past(trim_adr_r)]
    == $past(trim_val_r)) else $error("trim write lost");
  a_force_hold: assert property (force_r && !ctl_wr |=> force_r ##0
    wtrim_r[trim_adr_r] == TRIM_DEFAULT) else $error("force dropped");
  a_bypass_path: assert property (bypass_r |=> dac_data == $past(din_s))
    else $error("bypass data wrong");
  a_ext_quad: assert property (ext_r |=> quad_r == $past(qsel_r))
    else $error("external quadrant ignored");
  a_soft_force_default_trim: assert property (soft_p_r |=> cal_state_r == CS_FORCE_DEFAULT_TRIM && !busy)
    else $error("soft reset state");
  a_busy_ignore: assert property (busy && ctl_wr |=> cal_state_r != CS_USER || $past(
    cal_state_r == CS_USER)) else $error("write while busy");

  c_self_done: cover property (sc_done_ev);
  c_copy_done: cover property (cp_done_ev);
  c_user_write: cover property (wr_op);
  c_manual_upd: cover property (man_mode_r && man_upd && tgt != quad_r);
endmodule

// ==== verification/tb_dcsc_top.sv ====
`timescale 1ns/1ps
module tb_dcsc_top;
  import dcsc_pkg::*;
  logic        ref_clk;
  logic        rst_n;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic        cal_cmp;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  fac_addr;
  logic [5:0]  fac_data;
  logic [15:0] data_in;
  logic [15:0] dac_data;
  logic [1:0]  phase_quad;
  logic [31:0] lfsr_r = 32'h3f52;
  logic [16:0] exp_q[$];
  logic [16:0] ent;
  logic        rd_d1 = 1'b0;
  logic        rd_d2 = 1'b0;
  logic [7:0]  rd_val;
  logic [7:0]  ta;
  logic [7:0]  v;
  logic [15:0] old_w;
  logic [7:0]  ra[7] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h15, 8'h16, 8'h20};
  int          failures = 0;
  int          n_checks = 0;
  int          cnt;

  dcsc_top #(.SELF_CALIBRATION_START_CYCLES(8192), .COPY_CYCLES(4096)) dcsc_top_inst (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .reg_wr_en (reg_wr_en),
    .reg_rd_en (reg_rd_en),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .data_in   (data_in),
    .phase_quad(phase_quad),
    .cal_cmp   (cal_cmp),
    .dac_data  (dac_data),
    .fac_addr  (fac_addr),
    .fac_data  (fac_data)
  );

  // Factory memory stand-in, content derived from the address
  assign fac_data = fac_addr[5:0] ^ 6'h15;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t read got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t output got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_range(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[ERR] %0t duration %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
  endtask

  // Expectation noted first; the watcher pops it when the answer lands
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                    input logic chk = 1'b1);
    exp_q.push_back({chk, m, e});
    @(negedge ref_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    @(negedge ref_clk);
    rd_val = reg_rdata;
  endtask

  // Polls a done flag; each poll costs three cycles
  task automatic wait_flag(input int b, output int c);
    c = 0;
    rd_val = 8'h00;
    while (rd_val[b] !== 1'b1 && c < 3000) begin
      rd(ADDR_CAL_CTL, 8'h00, 8'h00, 1'b0);
      c += 3;
    end
  endtask

  task automatic done_test(input string name);
    $display("Test %s finished", name);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Read answer is valid one cycle after the taking edge
  always @(posedge ref_clk) begin
    rd_d1 <= reg_rd_en;
    rd_d2 <= rd_d1;
  end

  always @(negedge ref_clk) begin
    if (rd_d2 === 1'b1) begin
      ent = exp_q.pop_front();
      if (ent[16]) cmp8(reg_rdata & ent[15:8], ent[7:0] & ent[15:8]);
    end
  end

  // Generous bound: the sequence needs well under a thousand cycles
  initial begin
    #(20000 * 10);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    data_in = 16'h0000;
    phase_quad = 2'h0;
    cal_cmp = 1'b0;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    foreach (ra[i]) rd(ra[i], 8'h00, 8'hff);
    done_test("reset values");
    // User trim entry, readback and factory read
    lfsr_r = lfsr_next(lfsr_r);
    ta = lfsr_r[7:0];
    v = lfsr_r[15:8];
    wr(ADDR_TRIM_ADR, ta);
    wr(ADDR_TRIM_VAL, v);
    rd(ADDR_TRIM_ADR, ta, 8'hff);
    rd(ADDR_TRIM_VAL, {2'b00, v[5:0]}, 8'hff);
    wr(ADDR_CAL_CTL, 8'h08);
    wr(ADDR_TRIM_VAL, 8'h00);
    wr(ADDR_CAL_CTL, 8'h04);
    rd(ADDR_TRIM_VAL, {2'b00, v[5:0]}, 8'hff);
    rd(ADDR_CAL_CLK, 8'h30, 8'h30);
    wr(ADDR_CAL_CTL, 8'h02);
    rd(ADDR_TRIM_VAL, {2'b00, ta[5:0] ^ 6'h15}, 8'hff);
    done_test("trim access");
    // Soft reset keeps trims but reports uncalibrated
    wr(ADDR_SOFT_RST, 8'h80);
    rd(ADDR_SOFT_RST, 8'h00, 8'h80);
    rd(ADDR_CAL_CLK, 8'h00, 8'h30);
    wr(ADDR_CAL_CTL, 8'h04);
    rd(ADDR_TRIM_VAL, {2'b00, v[5:0]}, 8'hff);
    done_test("soft reset");
    // Copy duration scales with the divider; one tick at these sizes
    wr(ADDR_TRIM_ADR, 8'h00);
    for (int d = 7; d >= 6; d--) begin
      wr(ADDR_SOFT_RST, 8'h80);
      wr(ADDR_CAL_CLK, 8'(d));
      wr(ADDR_CAL_CTL, 8'h10);
      wait_flag(CP_DONE_BIT, cnt);
      cmp_range(cnt, (4096 >> d) / 2, (4096 >> d) + 24);
      rd(ADDR_CAL_CTL, 8'h20, 8'h30);
      rd(ADDR_CAL_CLK, 8'h20 | 8'(d), 8'h37);
    end
    wr(ADDR_CAL_CTL, 8'h04);
    rd(ADDR_TRIM_VAL, 8'h15, 8'hff);
    done_test("trim copy");
    // Self-calibration: two ticks, comparator says trim too high
    wr(ADDR_TRIM_VAL, 8'h2a);
    wr(ADDR_SOFT_RST, 8'h80);
    cal_cmp = 1'b1;
    wr(ADDR_CAL_CTL, 8'h40);
    // Trim write while busy must not land, else location 0 ends at 29
    wr(ADDR_CAL_CTL, 8'h08);
    wait_flag(SC_DONE_BIT, cnt);
    cmp_range(cnt, 64, 152);
    rd(ADDR_CAL_CTL, 8'h80, 8'hc0);
    rd(ADDR_CAL_CLK, 8'h10, 8'h30);
    wr(ADDR_CAL_CTL, 8'h04);
    rd(ADDR_TRIM_VAL, 8'h14, 8'hff);
    // Start with low bits set is refused; the force bit still lands
    wr(ADDR_CAL_CTL, 8'h41);
    repeat (20) @(negedge ref_clk);
    rd(ADDR_CAL_CTL, 8'h81, 8'hc1);
    rd(ADDR_CAL_CLK, 8'h00, 8'h30);
    done_test("self calibration");
    // Force-default bit holds until cleared
    wr(ADDR_CAL_CTL, 8'h01);
    repeat (20) @(negedge ref_clk);
    rd(ADDR_CAL_CTL, 8'h01, 8'h01);
    rd(ADDR_CAL_CLK, 8'h00, 8'h30);
    wr(ADDR_CAL_CTL, 8'h05);
    rd(ADDR_TRIM_VAL, 8'h3f, 8'hff);
    wr(ADDR_CAL_CTL, 8'h00);
    rd(ADDR_CAL_CTL, 8'h00, 8'h01);
    done_test("force default");
    // Quadrant sources and data path latency
    phase_quad = 2'h2;
    repeat (6) @(negedge ref_clk);
    rd(ADDR_QUADRANT, 8'h02, 8'h03);
    wr(ADDR_RESYNC, 8'h38);
    rd(ADDR_QUADRANT, 8'h03, 8'h03);
    rd(ADDR_RESYNC, 8'h38, 8'hff);
    repeat (12) @(negedge ref_clk);
    old_w = data_in;
    lfsr_r = lfsr_next(lfsr_r);
    data_in = lfsr_r[15:0];
    repeat (3) @(negedge ref_clk);
    cmp16(dac_data, old_w);
    repeat (12) @(negedge ref_clk);
    cmp16(dac_data, data_in);
    wr(ADDR_RESYNC, 8'h78);
    repeat (12) @(negedge ref_clk);
    lfsr_r = lfsr_next(lfsr_r);
    data_in = lfsr_r[15:0];
    repeat (3) @(negedge ref_clk);
    cmp16(dac_data, data_in);
    done_test("quadrant and data");
    // Manual mode holds the quadrant and raises the alarm
    wr(ADDR_SYNC_CTL, 8'h04);
    // External mode updates every cycle, so leave it for the auto source
    wr(ADDR_RESYNC, 8'h08);
    rd(ADDR_QUADRANT, 8'h03, 8'h03);
    rd(ADDR_STATUS, 8'h01, 8'h01);
    wr(ADDR_SYNC_CTL, 8'h06);
    rd(ADDR_QUADRANT, 8'h02, 8'h03);
    rd(ADDR_STATUS, 8'h00, 8'h01);
    done_test("manual update");
    finish_test();
  end
endmodule
